/* File: rtl/brs_pkg.sv */
package brs_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RESET_DELAY_MS  = 50;
    localparam int unsigned RESET_DELAY_CYC = (CLK_HZ / 1000) * RESET_DELAY_MS;
    localparam int unsigned SLOW_OSC_HZ     = 20_000;
    localparam int unsigned FAST_OSC_HZ     = 12_000_000;
    // slow oscillator tick divider while in start-up delay
    localparam int unsigned SLOW_DIV_CYC    = CLK_HZ / SLOW_OSC_HZ;
    // bounded wait for host activity before probing the eeprom
    localparam int unsigned HOST_WAIT_CYC   = 1000;
    // eeprom image size in bytes
    localparam int unsigned EE_IMAGE_BYTES  = 32768;
    localparam int unsigned PORT_PINS       = 32;

    // ----------------------------------------------------------------
    // pin positions of the boot functions
    // ----------------------------------------------------------------
    localparam int unsigned PIN_EE_SCL   = 28;
    localparam int unsigned PIN_EE_SDA   = 29;
    localparam int unsigned PIN_HOST_TX  = 30;
    localparam int unsigned PIN_HOST_RX  = 31;

    // ----------------------------------------------------------------
    // clock sources and reset default source
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BRS_SRC_RC   = 2'h0,
        BRS_SRC_XIN  = 2'h1,
        BRS_SRC_PLL  = 2'h2
    } brs_clksrc_t;

    localparam logic [1:0] CLKSRC_RST = 2'h0;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BRS_ST_SHUTDOWN = 3'h0,
        BRS_ST_DELAY    = 3'h1,
        BRS_ST_HOST     = 3'h2,
        BRS_ST_EEPROM   = 3'h3,
        BRS_ST_LAUNCH   = 3'h4,
        BRS_ST_RUN      = 3'h5,
        BRS_ST_SUSPEND  = 3'h6
    } brs_state_t;
endpackage

/* File: rtl/brs_sequencer.sv */
`timescale 1ns/1ns
module brs_sequencer
    import brs_pkg::*;
#(
    parameter int unsigned DELAY_CYC = brs_pkg::RESET_DELAY_CYC,
    parameter int unsigned HOST_WAIT = brs_pkg::HOST_WAIT_CYC,
    parameter int unsigned SLOW_DIV  = brs_pkg::SLOW_DIV_CYC
) (
    input  wire logic              clk_in,             // 10 MHz clock
    input  wire logic              rst_in,             // sync reset, high
    input  wire logic              external_reset_pin_in, // reset pin level, low = reset
    input  wire logic              brownout_enable_pin_in, // low = brown-out enabled
    input  wire logic              supply_low_in,      // supply below threshold
    input  wire logic              reboot_req_in,      // application reboot pulse
    input  wire logic              host_serial_rx_pin_in, // host rx pin level
    input  wire logic              host_found_in,      // loader: host conversation ok
    input  wire logic              host_suspend_in,    // loader: host sent suspend
    input  wire logic              host_load_done_in,  // loader: host download complete
    input  wire logic              ee_found_in,        // loader: eeprom acked probe
    input  wire logic              ee_byte_in,         // loader: one eeprom byte copied
    input  wire logic [1:0]        clk_src_sel_in,     // run-time source choice
    input  wire logic              xtal_mode_in,       // 1 = crystal, 0 = external osc
    output logic                   reset_pin_oe_n_out, // low = weak drive of reset pin
    output logic                   reset_pin_out_out,  // monitor level on reset pin
    output logic                   core0_en_out,       // core 0 enabled
    output logic                   cores_en_out,       // other cores allowed
    output logic                   core0_boot_out,     // core 0 runs boot loader
    output logic                   core0_interp_out,   // core 0 runs interpreter
    output logic                   sys_clk_en_out,     // internal clock running
    output logic                   osc_fast_out,       // 1 = fast rc, 0 = slow rc
    output logic                   slow_tick_out,      // slow oscillator tick pulse
    output brs_pkg::brs_clksrc_t   clk_src_out,        // selected clock source
    output logic                   xtal_drive_out,     // crystal feedback pin drive enable
    output logic                   boot_pins_out,      // pins 28..31 in boot role
    output logic                   pins_float_out,     // all port pins forced to input
    output logic                   probe_ee_out,       // loader: probe eeprom now
    output logic                   shutdown_out        // in shutdown
);
    import brs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        brs_state_t  st;
        logic [31:0] cnt;
        logic [15:0] ee_cnt;
        logic [15:0] div;
        logic        tick;
        brs_clksrc_t src;
        logic        xtal;
        logic        halt;    // parked in shutdown after a failed boot
    } brs_seq_t;

    brs_seq_t r_r;
    brs_seq_t r_nxt;

    logic external_reset_pin_s;
    logic brownout_enable_pin_s;
    logic slow_s;
    logic rx_s;
    logic shut_req;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    brs_sync #(.W(4)) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({external_reset_pin_in, brownout_enable_pin_in,
                  supply_low_in, host_serial_rx_pin_in}),
        .q_out  ({external_reset_pin_s, brownout_enable_pin_s, slow_s, rx_s})
    );

    // brown-out only counts when enabled; reset pin low or reboot also shut down
    assign shut_req = (!brownout_enable_pin_s && slow_s) || !external_reset_pin_s || reboot_req_in;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        r_nxt      = r_r;
        r_nxt.tick = 1'b0;
        // clock choice follows software at run time; the illegal code keeps the old one
        r_nxt.xtal = xtal_mode_in;
        if (clk_src_sel_in != 2'h3) begin
            r_nxt.src = brs_clksrc_t'(clk_src_sel_in);
        end
        if (shut_req) begin
            // shutdown wins over every state, reboot included
            r_nxt.st     = BRS_ST_SHUTDOWN;
            r_nxt.cnt    = '0;
            r_nxt.ee_cnt = '0;
            r_nxt.div    = '0;
            r_nxt.halt   = 1'b0;
        end else begin
            unique case (r_r.st)
                BRS_ST_SHUTDOWN: begin
                    // supply good and reset pin high together; a failed boot stays down
                    if (!r_r.halt) begin
                        r_nxt.st  = BRS_ST_DELAY;
                        r_nxt.cnt = '0;
                        r_nxt.div = '0;
                    end
                end
                BRS_ST_DELAY: begin
                    if (r_r.cnt == 32'(DELAY_CYC - 1)) begin
                        r_nxt.st  = BRS_ST_HOST;
                        r_nxt.cnt = '0;
                    end else begin
                        r_nxt.cnt = r_r.cnt + 32'h0000_0001;
                        // slow ticks only; none on the exit cycle, which is already fast
                        if (r_r.div == 16'(SLOW_DIV - 1)) begin
                            r_nxt.div  = '0;
                            r_nxt.tick = 1'b1;
                        end else begin
                            r_nxt.div = r_r.div + 16'h0001;
                        end
                    end
                end
                BRS_ST_HOST: begin
                    // host first; give up after HOST_WAIT cycles of rx idle high with no host
                    if (host_found_in && host_suspend_in) begin
                        r_nxt.st = BRS_ST_SUSPEND;
                    end else if (host_found_in && host_load_done_in) begin
                        r_nxt.st = BRS_ST_LAUNCH;
                    end else if (!host_found_in && rx_s &&
                                 r_r.cnt == 32'(HOST_WAIT - 1)) begin
                        r_nxt.st  = BRS_ST_EEPROM;
                        r_nxt.cnt = '0;
                    end else if (!host_found_in) begin
                        r_nxt.cnt = (rx_s) ? r_r.cnt + 32'h0000_0001 : '0;
                    end
                end
                BRS_ST_EEPROM: begin
                    // copy the whole image; no ack means nothing to boot
                    if (r_r.cnt == 32'(HOST_WAIT - 1) && !ee_found_in) begin
                        r_nxt.st   = BRS_ST_SHUTDOWN;
                        r_nxt.halt = 1'b1;
                    end else if (ee_found_in && ee_byte_in) begin
                        r_nxt.ee_cnt = r_r.ee_cnt + 16'h0001;
                        if (r_r.ee_cnt == 16'(EE_IMAGE_BYTES - 1)) begin
                            r_nxt.st = BRS_ST_LAUNCH;
                        end
                    end else if (!ee_found_in) begin
                        r_nxt.cnt = r_r.cnt + 32'h0000_0001;
                    end
                end
                BRS_ST_LAUNCH: begin
                    r_nxt.st = BRS_ST_RUN;
                end
                BRS_ST_RUN: begin
                    r_nxt.st = BRS_ST_RUN;
                end
                BRS_ST_SUSPEND: begin
                    r_nxt.st = BRS_ST_SUSPEND;
                end
                default: begin
                    r_nxt.st = BRS_ST_SHUTDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_r     <= '0;
            r_r.src <= brs_clksrc_t'(CLKSRC_RST);
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reset_pin_oe_n_out <= 1'b1;
            reset_pin_out_out  <= 1'b0;
            core0_en_out       <= 1'b0;
            cores_en_out       <= 1'b0;
            core0_boot_out     <= 1'b0;
            core0_interp_out   <= 1'b0;
            sys_clk_en_out     <= 1'b0;
            osc_fast_out       <= 1'b0;
            slow_tick_out      <= 1'b0;
            clk_src_out        <= BRS_SRC_RC;
            xtal_drive_out     <= 1'b0;
            boot_pins_out      <= 1'b0;
            pins_float_out     <= 1'b1;
            probe_ee_out       <= 1'b0;
            shutdown_out       <= 1'b1;
        end else begin
            // weak monitor drive; the pin's own low still resets
            reset_pin_oe_n_out <= brownout_enable_pin_s;
            reset_pin_out_out  <= r_nxt.st != BRS_ST_SHUTDOWN;
            core0_en_out       <= r_nxt.st inside {BRS_ST_HOST, BRS_ST_EEPROM,
                                                  BRS_ST_LAUNCH, BRS_ST_RUN};
            cores_en_out       <= r_nxt.st == BRS_ST_RUN;
            core0_boot_out     <= r_nxt.st inside {BRS_ST_HOST, BRS_ST_EEPROM};
            core0_interp_out   <= r_nxt.st == BRS_ST_RUN;
            sys_clk_en_out     <= r_nxt.st != BRS_ST_SHUTDOWN;
            osc_fast_out       <= !(r_nxt.st inside {BRS_ST_SHUTDOWN, BRS_ST_DELAY});
            slow_tick_out      <= r_nxt.tick;
            clk_src_out        <= (r_nxt.st == BRS_ST_RUN) ? r_nxt.src : BRS_SRC_RC;
            xtal_drive_out     <= (r_nxt.st == BRS_ST_RUN) && r_nxt.xtal &&
                                  (r_nxt.src != BRS_SRC_RC);
            boot_pins_out      <= r_nxt.st inside {BRS_ST_HOST, BRS_ST_EEPROM};
            pins_float_out     <= r_nxt.st inside {BRS_ST_SHUTDOWN, BRS_ST_DELAY};
            probe_ee_out       <= r_nxt.st == BRS_ST_EEPROM;
            shutdown_out       <= r_nxt.st == BRS_ST_SHUTDOWN;
        end
    end
endmodule

/* File: rtl/brs_sync.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------------------------------
module brs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,  // system clock
    input  wire logic         rst_in,  // sync reset
    input  wire logic [W-1:0] d_in,    // async inputs
    output logic      [W-1:0] q_out    // synchronised
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } brs_sync_t;

    brs_sync_t st_r;
    brs_sync_t st_nxt;

    // first stage read only by the second stage
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out = st_r.s2;
endmodule

/* File: verification/brs_checker.sv */
`timescale 1ns/1ns
// ----------------------------------------
// boot and shutdown port checks
// ----------------------------------------
module brs_checker
    import brs_pkg::*;
#(
    parameter int unsigned DELAY_CYC = 20
) (
    input wire logic                 clk_in,
    input wire logic                 rst_in,
    input wire logic                 external_reset_pin_in,
    input wire logic                 brownout_enable_pin_in,
    input wire logic                 supply_low_in,
    input wire logic                 reboot_req_in,
    input wire logic [1:0]           clk_src_sel_in,
    input wire logic                 reset_pin_oe_n_out,
    input wire logic                 core0_en_out,
    input wire logic                 cores_en_out,
    input wire logic                 core0_boot_out,
    input wire logic                 core0_interp_out,
    input wire logic                 sys_clk_en_out,
    input wire logic                 osc_fast_out,
    input wire logic                 slow_tick_out,
    input wire brs_pkg::brs_clksrc_t clk_src_out,
    input wire logic                 boot_pins_out,
    input wire logic                 pins_float_out,
    input wire logic                 shutdown_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // cycles spent out of shutdown on the slow oscillator
    int unsigned dly_r;
    always_ff @(posedge clk_in) begin
        dly_r <= (rst_in || shutdown_out) ? 0 : dly_r + (osc_fast_out ? 0 : 1);
    end
    // a few cycles of margin cover the input synchronisers
    sequence pin_low_s;
        !external_reset_pin_in [*5];
    endsequence
    sequence brown_s;
        (supply_low_in && !brownout_enable_pin_in) [*6];
    endsequence
    sequence boot_up_s;
        $rose(osc_fast_out);
    endsequence
    AST_SHUT_FLOAT: assert property (shutdown_out |-> pins_float_out && !core0_en_out
        && !cores_en_out && !sys_clk_en_out) else $error("shutdown leaves core or pin live");
    AST_PIN_LOW: assert property (pin_low_s |-> shutdown_out && !core0_en_out)
        else $error("reset pin low but not in shutdown");
    AST_BROWNOUT: assert property (brown_s |-> shutdown_out)
        else $error("enabled brown-out did not shut down");
    AST_MONITOR: assert property ($stable(brownout_enable_pin_in) [*5] |->
        reset_pin_oe_n_out == brownout_enable_pin_in) else $error("reset pin drive wrong");
    AST_DELAY: assert property (boot_up_s |-> dly_r == DELAY_CYC)
        else $error("start-up delay length wrong");
    AST_TICK: assert property (slow_tick_out |-> !osc_fast_out && !shutdown_out
        ##1 !slow_tick_out) else $error("slow tick outside delay");
    AST_BOOT: assert property (boot_up_s |-> core0_en_out && core0_boot_out
        && boot_pins_out && !pins_float_out) else $error("boot loader not started");
    AST_INTERP: assert property (core0_interp_out |-> !core0_boot_out
        && !boot_pins_out && cores_en_out) else $error("run state outputs wrong");
    AST_REBOOT: assert property (reboot_req_in |=> shutdown_out)
        else $error("reboot did not shut down");
    AST_SRC_HOLD: assert property (clk_src_sel_in == 2'h3 |=>
        shutdown_out || $stable(clk_src_out)) else $error("illegal source taken");
endmodule

bind brs_sequencer brs_checker #(.DELAY_CYC(DELAY_CYC)) u_brs_checker (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .external_reset_pin_in  (external_reset_pin_in),
    .brownout_enable_pin_in (brownout_enable_pin_in),
    .supply_low_in          (supply_low_in),
    .reboot_req_in          (reboot_req_in),
    .clk_src_sel_in         (clk_src_sel_in),
    .reset_pin_oe_n_out     (reset_pin_oe_n_out),
    .core0_en_out           (core0_en_out),
    .cores_en_out           (cores_en_out),
    .core0_boot_out         (core0_boot_out),
    .core0_interp_out       (core0_interp_out),
    .sys_clk_en_out         (sys_clk_en_out),
    .osc_fast_out           (osc_fast_out),
    .slow_tick_out          (slow_tick_out),
    .clk_src_out            (clk_src_out),
    .boot_pins_out          (boot_pins_out),
    .pins_float_out         (pins_float_out),
    .shutdown_out           (shutdown_out)
);

/* File: verification/brs_loader_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// host and eeprom stand-in for the loader
// ----------------------------------------
module brs_loader_model (
    input  wire logic        clk_in,       // system clock
    input  wire logic        boot_in,      // core 0 in boot loader
    input  wire logic        probe_in,     // eeprom probe request
    input  wire logic [1:0]  mode_in,      // 0 run,1 suspend,2 eeprom,3 absent
    output logic             rx_out,       // host serial line
    output logic             found_out,    // host answered
    output logic             suspend_out,  // host asked to suspend
    output logic             done_out,     // download complete
    output logic             ee_found_out, // eeprom acked
    output logic             ee_byte_out,  // byte copied pulse
    output logic [16:0]      ee_count_out  // bytes copied so far
);
    logic [3:0] host_cnt;
    logic       host;
    assign host = boot_in && !mode_in[1];
    initial begin
        {rx_out, found_out, suspend_out, done_out} = 4'h8;
        {ee_found_out, ee_byte_out, host_cnt, ee_count_out} = '0;
    end
    // host toggles rx while present; the idle line rests high on its pull-up
    always @(posedge clk_in) begin
        rx_out <= host ? !rx_out : 1'b1;
        host_cnt <= host ? host_cnt + {3'h0, host_cnt != 4'hf} : 4'h0;
        found_out <= host && host_cnt >= 4'h4;
        done_out <= host && host_cnt >= 4'h8;
        suspend_out <= host && mode_in == 2'h1;
        if (probe_in && mode_in == 2'h2) begin
            ee_found_out <= 1'b1;
        end else if (!boot_in && !probe_in) begin
            ee_found_out <= 1'b0;
        end
        // the image is exactly 32 KB, so pulses stop at 32768; alternate cycles
        ee_byte_out <= ee_found_out && !ee_byte_out && ee_count_out < 17'h8000;
        if (boot_in && !probe_in && !ee_found_out) begin
            ee_count_out <= '0;
        end else if (ee_byte_out) begin
            ee_count_out <= ee_count_out + 17'h1;
        end
    end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import brs_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, rpin = 1'b1, brownout_enable_pin = 1'b1, slow = 1'b0, reboot = 1'b0;
    logic [1:0] sel = 2'h0, mode = 2'h0;
    logic xmode = 1'b0, rx, fnd, susp, done, eef, eeb, oe_n, rpo, c0, cs, boot, interp;
    logic clken, fast, tick, xd, bp, flt, probe, sd;
    logic [16:0] eecnt;
    brs_clksrc_t src;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_tick = 0;
    always #50 clk_in = !clk_in;
    // slow ticks seen, counted where the pulse is settled
    always @(negedge clk_in) begin
        if (tick === 1'b1) begin
            n_tick <= n_tick + 1;
        end
    end
    brs_sequencer #(.DELAY_CYC(20), .HOST_WAIT(8), .SLOW_DIV(5)) u_brs_sequencer (
        .clk_in(clk_in),
        .rst_in(rst_in), .external_reset_pin_in(rpin), .brownout_enable_pin_in(brownout_enable_pin),
        .supply_low_in(slow), .reboot_req_in(reboot), .host_serial_rx_pin_in(rx),
        .host_found_in(fnd), .host_suspend_in(susp), .host_load_done_in(done),
        .ee_found_in(eef), .ee_byte_in(eeb), .clk_src_sel_in(sel), .xtal_mode_in(xmode),
        .reset_pin_oe_n_out(oe_n), .reset_pin_out_out(rpo), .core0_en_out(c0),
        .cores_en_out(cs), .core0_boot_out(boot), .core0_interp_out(interp),
        .sys_clk_en_out(clken), .osc_fast_out(fast), .slow_tick_out(tick),
        .clk_src_out(src), .xtal_drive_out(xd), .boot_pins_out(bp), .pins_float_out(flt),
        .probe_ee_out(probe), .shutdown_out(sd));
    brs_loader_model u_brs_loader_model (.clk_in(clk_in), .boot_in(boot), .probe_in(probe),
        .mode_in(mode), .rx_out(rx), .found_out(fnd), .suspend_out(susp), .done_out(done),
        .ee_found_out(eef), .ee_byte_out(eeb), .ee_count_out(eecnt));
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return sd;
            1: return fast;
            default: return interp;
        endcase
    endfunction
    // bounded wait, sampled at the falling edge where outputs are settled
    task automatic wait_on(input int k, input logic v, input int lim);
        repeat (lim) begin
            @(negedge clk_in);
            if (sig(k) === v) break;
        end
        chk(sig(k), v);
    endtask
    // wait n cycles, ending on a settled sampling point
    task automatic go(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic boot_to(input logic [1:0] m);
        @(posedge clk_in);
        mode <= m;
        reboot <= 1'b1;
        @(posedge clk_in);
        reboot <= 1'b0;
        wait_on(0, 1'b1, 2);
        chk(flt, 1'b1);
        wait_on(1, 1'b1, 40);
        chk({c0, boot, bp}, 3'h7);
    endtask
    task automatic t_src();
        @(posedge clk_in);
        sel <= 2'h1;
        xmode <= 1'b1;
        go(3);
        chk(src, BRS_SRC_XIN);
        chk(xd, 1'b1);
        @(posedge clk_in);
        xmode <= 1'b0;
        sel <= 2'h3;
        go(3);
        chk(xd, 1'b0);
        chk(src, BRS_SRC_XIN);
        @(posedge clk_in);
        sel <= 2'h2;
        go(3);
        chk(src, BRS_SRC_PLL);
        @(posedge clk_in);
        sel <= 2'h0;
        go(3);
        chk(src, BRS_SRC_RC);
    endtask
    task automatic t_pin();
        @(posedge clk_in);
        rpin <= 1'b0;
        go(6);
        chk({sd, flt, c0, cs, clken, rpo}, 6'h30);
        @(posedge clk_in);
        rpin <= 1'b1;
        wait_on(0, 1'b0, 6);
        chk(rpo, 1'b1);
        wait_on(2, 1'b1, 80);
    endtask
    task automatic t_brown();
        @(posedge clk_in);
        slow <= 1'b1;
        go(8);
        chk({sd, oe_n}, 2'h1);
        @(posedge clk_in);
        brownout_enable_pin <= 1'b0;
        go(8);
        chk({sd, oe_n}, 2'h2);
        @(posedge clk_in);
        slow <= 1'b0;
        wait_on(1, 1'b1, 40);
        @(posedge clk_in);
        brownout_enable_pin <= 1'b1;
    endtask
    task automatic t_ee();
        boot_to(2'h2);
        repeat (70000) begin
            @(negedge clk_in);
            if (interp === 1'b1) break;
        end
        chk(interp, 1'b1);
        chk(eecnt, 17'h8000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_in);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        wait_on(1, 1'b1, 40);
        chk(17'(n_tick), 17'h3);
        wait_on(2, 1'b1, 60);
        chk({cs, bp}, 2'h2);
        t_src();
        t_pin();
        t_brown();
        boot_to(2'h1);
        go(40);
        chk({interp, c0}, 2'h0);
        boot_to(2'h3);
        wait_on(0, 1'b1, 80);
        chk({flt, c0}, 2'h2);
        go(20);
        chk(sd, 1'b1);
        t_ee();
        tally_and_finish();
    end
endmodule
